// file: bench/fpmu_tb.sv
// Self-checking random and corner-case testbench of the fixed-point multiply unit
`timescale 1ns/1ps
module testbench;
  import fpmu_pkg::*;
  // ****************************************
  // Stimulus, outputs and reference state
  // ****************************************
  localparam int NUM_CYC = 3000;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic issue_i = 1'b0, round_i = 1'b0, t3_write_i = 1'b0;
  logic flag_clear_i = 1'b0, acc_load_i = 1'b0;
  logic fractional_mode_bit_i = 1'b0, forty_bit_mode_bit_i = 1'b0;
  logic rounding_mode_bit_i = 1'b0, datapath_saturation_bit_i = 1'b0;
  logic saturate_on_multiply_bit_i = 1'b0, legacy_compat_mode_bit_i = 1'b0;
  fpmu_op_type op_i = FPMU_OP_NONE;
  logic [7:0] opcode_i = 8'h00, byte_immediate_i = 8'h00;
  logic [1:0] src_sel_i = 2'h0, dst_sel_i = 2'h0, flag_clear_sel_i = 2'h0;
  logic [15:0] temp_i = 16'h0000, halfword_immediate_i = 16'h0000;
  logic [15:0] data_operand_i = 16'h0000, coef_operand_i = 16'h0000;
  logic [39:0] acc_load_data_i = 40'h0000000000;
  logic [39:0] acc0_o, acc1_o, acc2_o, acc3_o;
  logic [3:0] dest_accum_overflow_flag_o;
  logic [15:0] third_temp_register_o;
  logic done_o, illegal_o;
  logic [39:0] acc_m [4];
  logic [3:0] flag_m;
  logic [15:0] t3_m;
  logic done_m, illegal_m;
  logic [31:0] lfsr_state = 32'h61D2;
  int fails = 0;
  int comparisons = 0;

  // Free-running core clock, 100 MHz
  always #5 clk_sys_i = ~clk_sys_i;

  fpmu_top fpmu_top_i (
    .clk_sys_i, .resetn_i, .issue_i, .op_i, .opcode_i, .round_i, .t3_write_i, .src_sel_i,
    .dst_sel_i, .temp_i, .byte_immediate_i, .halfword_immediate_i, .data_operand_i,
    .coef_operand_i, .fractional_mode_bit_i, .forty_bit_mode_bit_i, .rounding_mode_bit_i,
    .datapath_saturation_bit_i, .saturate_on_multiply_bit_i, .legacy_compat_mode_bit_i,
    .flag_clear_i, .flag_clear_sel_i, .acc_load_i, .acc_load_data_i, .acc0_o, .acc1_o,
    .acc2_o, .acc3_o, .dest_accum_overflow_flag_o, .third_temp_register_o, .done_o, .illegal_o
  );

  // ****************************************
  // Reference functions and checks
  // ****************************************
  // Whole-word step so consecutive draws are not mere shifts of each other
  function automatic logic [31:0] next_rand();
    repeat (32) begin
      lfsr_state = {lfsr_state[30:0],
        lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    end
    return lfsr_state;
  endfunction

  function automatic logic [7:0] legal_opc(input fpmu_op_type op, input logic e);
    case (op)
      FPMU_OP_IMM8: return {OPC_IMM8_PFX, e};
      FPMU_OP_IMM16: return OPC_IMM16_PFX;
      FPMU_OP_MEM_COEF: return OPC_COEF_PFX;
      FPMU_OP_MEM_ACC: return OPC_MEMACC_PFX;
      default: return {e, 7'h2A};
    endcase
  endfunction

  // Shift, extend, round, detect, saturate, in that order
  function automatic logic [39:0] mul_exp(input logic [16:0] a, input logic [16:0] b,
      input logic chk, output logic ovf);
    logic signed [33:0] p;
    logic [39:0] v;
    logic s, tie;
    p = $signed(a) * $signed(b);
    if (fractional_mode_bit_i) p = p <<< 1;
    if (fractional_mode_bit_i && saturate_on_multiply_bit_i && p == 34'sh080000000) begin
      p = 34'sh07FFFFFFF;
    end
    // Only the low 32 bits of the product are sign-extended into the accumulator
    v = {{8{p[31]}}, p[31:0]};
    s = v[39];
    if (round_i) begin
      tie = v[15:0] == 16'h8000;
      v = (v + ROUND_ADD) & ROUND_LOW_MASK;
      if (rounding_mode_bit_i && tie) v[16] = 1'b0;
    end
    ovf = chk && (forty_bit_mode_bit_i ? (!s && v[39]) : !(&v[39:31] || !(|v[39:31])));
    if (ovf && datapath_saturation_bit_i) begin
      v = forty_bit_mode_bit_i ? SAT_POS_40 : (s ? SAT_NEG_32 : SAT_POS_32);
    end
    return v;
  endfunction

  task automatic check40(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reset_model();
    acc_m = '{default: ACC_RESET};
    flag_m = 4'h0;
    t3_m = TEMP_RESET;
    done_m = 1'b0;
    illegal_m = 1'b0;
  endtask

  task automatic set_modes(input logic [5:0] m);
    {fractional_mode_bit_i, forty_bit_mode_bit_i, rounding_mode_bit_i,
      datapath_saturation_bit_i, saturate_on_multiply_bit_i, legacy_compat_mode_bit_i} = m;
  endtask

  // Predict this cycle's effect, let one edge pass, then compare everything
  task automatic apply();
    logic [16:0] a, b;
    logic [39:0] r;
    logic ovf, mul, mem;
    a = acc_m[src_sel_i][32:16];
    b = {temp_i[15], temp_i};
    mem = op_i inside {FPMU_OP_MEM_COEF, FPMU_OP_MEM_ACC, FPMU_OP_MEM_IMM8};
    if (mem && op_i != FPMU_OP_MEM_ACC) a = {data_operand_i[15], data_operand_i};
    case (op_i)
      FPMU_OP_IMM8, FPMU_OP_MEM_IMM8: b = {{9{byte_immediate_i[7]}}, byte_immediate_i};
      FPMU_OP_IMM16: b = {halfword_immediate_i[15], halfword_immediate_i};
      FPMU_OP_MEM_COEF: b = {coef_operand_i[15], coef_operand_i};
      FPMU_OP_MEM_ACC: b = {data_operand_i[15], data_operand_i};
      default: b = b;
    endcase
    r = mul_exp(a, b, !(op_i inside {FPMU_OP_IMM8, FPMU_OP_MEM_IMM8}), ovf);
    mul = resetn_i && issue_i && op_i != FPMU_OP_NONE;
    done_m = mul && ((op_i inside {FPMU_OP_TEMP, FPMU_OP_MEM_IMM8}) ||
      opcode_i == legal_opc(op_i, opcode_i[0]));
    illegal_m = mul && !done_m;
    if (flag_clear_i) flag_m[flag_clear_sel_i] = 1'b0;
    if (done_m) begin
      acc_m[dst_sel_i] = r;
      flag_m[dst_sel_i] = flag_m[dst_sel_i] | ovf;
      if (mem && t3_write_i) t3_m = data_operand_i;
    end else if (acc_load_i) begin
      acc_m[dst_sel_i] = acc_load_data_i;
    end
    @(posedge clk_sys_i);
    #1;
    if (!resetn_i) reset_model();
    check40(acc0_o, acc_m[0]);
    check40(acc1_o, acc_m[1]);
    check40(acc2_o, acc_m[2]);
    check40(acc3_o, acc_m[3]);
    check16({12'h000, dest_accum_overflow_flag_o}, {12'h000, flag_m});
    check16(third_temp_register_o, t3_m);
    check16({14'h0000, done_o, illegal_o}, {14'h0000, done_m, illegal_m});
  endtask

  // ****************************************
  // Stimulus sequences
  // ****************************************
  // Issue three in four cycles; one opcode in eight is corrupted, refused only by the four prefix-checked forms
  task automatic rand_inputs();
    logic [31:0] r0, r1, r2;
    r0 = next_rand();
    r1 = next_rand();
    r2 = next_rand();
    issue_i = r0[0] | r0[1];
    op_i = fpmu_op_type'(3'(r0[4:2] % 3'd7));
    opcode_i = legal_opc(op_i, r0[5]) ^ ((r0[8:6] == 3'h0) ? 8'h10 : 8'h00);
    round_i = r0[9];
    t3_write_i = r0[10];
    src_sel_i = r0[12:11];
    dst_sel_i = r0[14:13];
    set_modes(r0[20:15]);
    flag_clear_i = r0[23:21] == 3'h0;
    flag_clear_sel_i = r0[25:24];
    acc_load_i = !issue_i;
    acc_load_data_i = {r0[31:24], r1};
    temp_i = r1[15:0];
    byte_immediate_i = r1[23:16];
    coef_operand_i = r1[31:16]; // Always an on-chip word
    halfword_immediate_i = r2[15:0];
    data_operand_i = r2[31:16];
  endtask

  // Preload accumulator 1, multiply into 2, then clear flag 2
  task automatic corner(input fpmu_op_type op, input logic [39:0] av, input logic [15:0] x,
      input logic [5:0] md, input logic rd);
    issue_i = 1'b0;
    acc_load_i = 1'b1;
    dst_sel_i = 2'h1;
    acc_load_data_i = av;
    apply();
    acc_load_i = 1'b0;
    issue_i = 1'b1;
    op_i = op;
    opcode_i = legal_opc(op, 1'b1);
    src_sel_i = 2'h1;
    dst_sel_i = 2'h2;
    {temp_i, halfword_immediate_i, data_operand_i, coef_operand_i} = {4{x}};
    byte_immediate_i = x[7:0];
    t3_write_i = 1'b1;
    set_modes(md);
    round_i = rd;
    apply();
    issue_i = 1'b0;
    flag_clear_i = 1'b1;
    flag_clear_sel_i = 2'h2;
    apply();
  endtask

  initial begin
    reset_model();
    repeat (3) apply();
    resetn_i = 1'b1;
    // Most negative operands squared: clamp, 32-bit sign wrap to FF80000000 with no saturation, and the 40-bit pass-through
    corner(FPMU_OP_TEMP, 40'h0180000000, 16'h8000, 6'b100010, 1'b0);
    corner(FPMU_OP_TEMP, 40'h0180000000, 16'h8000, 6'b100100, 1'b0);
    corner(FPMU_OP_TEMP, 40'h0180000000, 16'h8000, 6'b110100, 1'b0);
    // Rounding carries into bit 31: saturates in 32-bit mode, passes in 40-bit mode
    corner(FPMU_OP_TEMP, 40'h0100010000, 16'h8000, 6'b000100, 1'b1);
    corner(FPMU_OP_TEMP, 40'h0100010000, 16'h8000, 6'b010100, 1'b1);
    // Exact rounding tie under both rounding methods
    corner(FPMU_OP_TEMP, 40'h0000030000, 16'h8000, 6'b000000, 1'b1);
    corner(FPMU_OP_TEMP, 40'h0000030000, 16'h8000, 6'b001000, 1'b1);
    for (int k = 1; k < 7; k++) begin
      corner(fpmu_op_type'(3'(k)), 40'h0180000000, 16'h8000, 6'b100101, 1'b1);
    end
    // Back-to-back random traffic with a reset in mid-run
    for (int n = 0; n < NUM_CYC; n++) begin
      if (n == NUM_CYC / 2) begin
        resetn_i = 1'b0;
        apply();
        resetn_i = 1'b1;
      end
      rand_inputs();
      apply();
    end
    tally_and_finish();
  end

  // Watchdog sized at about twice the expected run
  initial begin
    #((NUM_CYC + 200) * 20);
    fails++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
endmodule

// file: hdl/fpmu_postproc.sv
// Combinational post-processing of a raw signed product
`timescale 1ns/1ps
module fpmu_postproc (
  fpmu_post_if.post pp  // Product in, processed result out
);
  import fpmu_pkg::*;

  logic [PROD_W-1:0] shifted;
  logic [ACC_W-1:0] extended;
  logic [ACC_W-1:0] rounded;
  logic saturate_on_multiply_bit_hit;
  logic ovf32;
  logic ovf40;

  // Fractional shift, then 40-bit sign extension, then rounding
  always_comb begin
    shifted = pp.fractional_mode_bit ? {pp.raw_prod[PROD_W-2:0], 1'b0} : pp.raw_prod;
    // Saturate-on-multiply clamps the one fractional corner case
    saturate_on_multiply_bit_hit = pp.ovf_enable && pp.saturate_on_multiply_bit && pp.fractional_mode_bit
      && (shifted == SATURATE_ON_MULTIPLY_BIT_CORNER);
    extended = {{(ACC_W-32){shifted[31]}}, shifted[31:0]};
    if (saturate_on_multiply_bit_hit) begin
      extended = SAT_POS_32;
    end
    rounded = extended;
    if (pp.round_req) begin
      // Unbiased mode clears the low bit on an exact tie
      rounded = (extended + ROUND_ADD) & ROUND_LOW_MASK;
      if (pp.rounding_mode_bit && (extended[15:0] == 16'h8000)) begin
        rounded[16] = 1'b0;
      end
    end
  end

  // Overflow detection on 32 or 40 bits, then saturation
  always_comb begin
    ovf32 = (rounded[39:31] != {9{rounded[31]}});
    ovf40 = pp.round_req && !extended[39] && rounded[39]; // Carry into bit 39
    pp.overflow = pp.ovf_enable && (pp.forty_bit_mode_bit ? ovf40 : ovf32);
    pp.result = rounded;
    if (pp.overflow && pp.datapath_saturation_bit) begin
      if (pp.forty_bit_mode_bit) begin
        pp.result = extended[39] ? SAT_NEG_40 : SAT_POS_40;
      end else begin
        pp.result = rounded[39] ? SAT_NEG_32 : SAT_POS_32;
      end
    end
  end
endmodule

// file: hdl/fpmu_top.sv
// Single-cycle fixed-point multiply unit with accumulator file
// ****************************************
// Summary of operation
// - Temp form multiplies source accumulator bits 32-16 by sign-extended temp.
// - Fractional mode shifts raw product left one bit first.
// - Product is sign-extended from 32 to 40 bits.
// - Rounding happens only on request, method picked by rounding mode.
// - Forty-bit mode picks overflow check; overflow sets destination flag.
// - On overflow, saturation mode decides whether accumulator saturates.
// - Saturate-on-multiply bit governs the multiplication overflow case.
// - Byte immediate form, prefix 0001 111E, accumulator times byte constant.
// - Byte-constant forms never detect overflow, saturate or touch flags.
// - Halfword immediate form, prefix 0111 1001, accumulator times constant.
// - Coefficient form, prefix 1101 0001, memory times coefficient operand.
// - Memory forms may copy the data operand into third temp register.
// - Memory-accumulator form, ending 00SS, updates destination overflow flag.
// - Every form completes in one cycle and may be repeated.
// - Legacy mode gives compatible results when forty-bit mode is clear.
// ****************************************
`timescale 1ns/1ps
module fpmu_top (
  input wire logic clk_sys_i,                                     // Core clock
  input wire logic resetn_i,                                      // Async reset, low
  input wire logic issue_i,                                       // Instruction valid
  input wire fpmu_pkg::fpmu_op_type op_i,                         // Multiply form
  input wire logic [7:0] opcode_i,                                // First opcode byte
  input wire logic round_i,                                       // Rounding keyword
  input wire logic t3_write_i,                                    // Copy data to temp 3
  input wire logic [fpmu_pkg::ACC_IDX_W-1:0] src_sel_i,           // Source accumulator
  input wire logic [fpmu_pkg::ACC_IDX_W-1:0] dst_sel_i,           // Destination
  input wire logic [fpmu_pkg::DATA_W-1:0] temp_i,                 // Temporary register
  input wire logic [fpmu_pkg::BYTE_W-1:0] byte_immediate_i,       // 8-bit constant
  input wire logic [fpmu_pkg::DATA_W-1:0] halfword_immediate_i,   // 16-bit constant
  input wire logic [fpmu_pkg::DATA_W-1:0] data_operand_i,         // Data memory word
  input wire logic [fpmu_pkg::DATA_W-1:0] coef_operand_i,         // Coefficient word
  input wire logic fractional_mode_bit_i,                         // Fractional mode
  input wire logic forty_bit_mode_bit_i,                          // 40-bit mode
  input wire logic rounding_mode_bit_i,                           // Rounding method
  input wire logic datapath_saturation_bit_i,                     // Saturate on overflow
  input wire logic saturate_on_multiply_bit_i,                    // Multiply saturation
  input wire logic legacy_compat_mode_bit_i,                      // Legacy mode
  input wire logic flag_clear_i,                                  // Clear selected flag
  input wire logic [fpmu_pkg::ACC_IDX_W-1:0] flag_clear_sel_i,    // Flag to clear
  input wire logic acc_load_i,                                    // Load accumulator
  input wire logic [fpmu_pkg::ACC_W-1:0] acc_load_data_i,         // Load value
  output logic [fpmu_pkg::ACC_W-1:0] acc0_o,                      // Accumulator 0
  output logic [fpmu_pkg::ACC_W-1:0] acc1_o,                      // Accumulator 1
  output logic [fpmu_pkg::ACC_W-1:0] acc2_o,                      // Accumulator 2
  output logic [fpmu_pkg::ACC_W-1:0] acc3_o,                      // Accumulator 3
  output logic [fpmu_pkg::NUM_ACC-1:0] dest_accum_overflow_flag_o, // Overflow flags
  output logic [fpmu_pkg::DATA_W-1:0] third_temp_register_o,      // Temp 3
  output logic done_o,                                            // Result written
  output logic illegal_o                                          // Opcode mismatch
);
  import fpmu_pkg::*;

  // ****************************************
  // Storage and local signals
  // ****************************************
  logic [ACC_W-1:0] acc [NUM_ACC];
  logic [NUM_ACC-1:0] ovf_flag;
  logic [DATA_W-1:0] third_temp_register;
  logic done;
  logic illegal;
  logic [OPND_W-1:0] opnd_a;
  logic [OPND_W-1:0] opnd_b;
  logic [ACC_W-1:0] src_acc;
  logic [ACC_W-1:0] dst_acc;
  logic opcode_ok;
  logic is_mult;
  logic is_mem;
  logic ovf_forms;
  logic write_en;
  logic signed [PROD_W-1:0] mul_a;
  logic signed [PROD_W-1:0] mul_b;
  fpmu_post_if pp ();

  assign src_acc = acc[src_sel_i];
  assign dst_acc = acc[dst_sel_i];

  // Operand selection and sign extension to 17 bits
  always_comb begin
    opnd_a = src_acc[ACC_MUL_HI:ACC_MUL_LO];
    opnd_b = '0;
    case (op_i)
      FPMU_OP_TEMP: begin
        opnd_b = {temp_i[DATA_W-1], temp_i};
      end
      FPMU_OP_IMM8: begin
        opnd_b = {{(OPND_W-BYTE_W){byte_immediate_i[BYTE_W-1]}}, byte_immediate_i};
      end
      FPMU_OP_IMM16: begin
        opnd_b = {halfword_immediate_i[DATA_W-1], halfword_immediate_i};
      end
      FPMU_OP_MEM_COEF: begin
        opnd_a = {data_operand_i[DATA_W-1], data_operand_i};
        opnd_b = {coef_operand_i[DATA_W-1], coef_operand_i};
      end
      FPMU_OP_MEM_ACC: begin
        opnd_b = {data_operand_i[DATA_W-1], data_operand_i};
      end
      FPMU_OP_MEM_IMM8: begin
        opnd_a = {data_operand_i[DATA_W-1], data_operand_i};
        opnd_b = {{(OPND_W-BYTE_W){byte_immediate_i[BYTE_W-1]}}, byte_immediate_i};
      end
      default: begin
        opnd_b = '0;
      end
    endcase
  end

  // Opcode prefix check for forms with a fixed prefix
  always_comb begin
    case (op_i)
      FPMU_OP_IMM8: opcode_ok = (opcode_i[7:1] == OPC_IMM8_PFX);
      FPMU_OP_IMM16: opcode_ok = (opcode_i == OPC_IMM16_PFX);
      FPMU_OP_MEM_COEF: opcode_ok = (opcode_i == OPC_COEF_PFX);
      FPMU_OP_MEM_ACC: opcode_ok = (opcode_i == OPC_MEMACC_PFX);
      default: opcode_ok = 1'b1;
    endcase
  end

  assign is_mult = issue_i && (op_i != FPMU_OP_NONE);
  assign write_en = is_mult && opcode_ok;
  assign is_mem = (op_i == FPMU_OP_MEM_COEF) || (op_i == FPMU_OP_MEM_ACC)
    || (op_i == FPMU_OP_MEM_IMM8);
  // Byte-constant forms never flag or saturate
  assign ovf_forms = (op_i != FPMU_OP_IMM8) && (op_i != FPMU_OP_MEM_IMM8);

  // ****************************************
  // Multiplier core and post-processing
  // ****************************************
  // Legacy mode needs no extra path: 32-bit checks already match old results
  // Widen before multiplying: a product sized by its 17-bit operands loses its top half
  assign mul_a = PROD_W'($signed(opnd_a));
  assign mul_b = PROD_W'($signed(opnd_b));
  assign pp.raw_prod = mul_a * mul_b;
  assign pp.fractional_mode_bit = fractional_mode_bit_i;
  assign pp.forty_bit_mode_bit = forty_bit_mode_bit_i;
  assign pp.rounding_mode_bit = rounding_mode_bit_i;
  assign pp.datapath_saturation_bit = datapath_saturation_bit_i && ovf_forms;
  assign pp.saturate_on_multiply_bit = saturate_on_multiply_bit_i;
  assign pp.round_req = round_i;
  assign pp.ovf_enable = ovf_forms;

  fpmu_postproc u_post (
    .pp(pp.post)
  );

  // ****************************************
  // Architectural state updates
  // ****************************************
  // Accumulator write, one cycle per form; multiply wins over a load
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc[i] <= ACC_RESET;
      end
    end else if (write_en) begin
      acc[dst_sel_i] <= pp.result;
    end else if (acc_load_i) begin
      acc[dst_sel_i] <= acc_load_data_i;
    end
  end

  // Sticky overflow flags: a new overflow beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_ACC; i++) begin
        if (write_en && pp.overflow && (dst_sel_i == ACC_IDX_W'(i))) begin
          ovf_flag[i] <= 1'b1;
        end else if (flag_clear_i && (flag_clear_sel_i == ACC_IDX_W'(i))) begin
          ovf_flag[i] <= 1'b0;
        end
      end
    end
  end

  // Optional copy of the data operand into temp 3
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      third_temp_register <= TEMP_RESET;
    end else if (write_en && is_mem && t3_write_i) begin
      third_temp_register <= data_operand_i;
    end
  end

  // Completion and mismatch strobes
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= write_en;
      illegal <= is_mult && !opcode_ok;
    end
  end

  assign acc0_o = acc[0];
  assign acc1_o = acc[1];
  assign acc2_o = acc[2];
  assign acc3_o = acc[3];
  assign dest_accum_overflow_flag_o = ovf_flag;
  assign third_temp_register_o = third_temp_register;
  assign done_o = done;
  assign illegal_o = illegal;

  // ****************************************
  // Checks
  // ****************************************
  sequence mult_issue_s;
    write_en;
  endsequence

  single_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    mult_issue_s |=> done)
    else $error("multiply did not complete in one cycle");

  byte_noflag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && !ovf_forms && !flag_clear_i) |=> $stable(ovf_flag))
    else $error("byte constant form changed a flag");

  ovf_sets_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && pp.overflow) |=> ovf_flag[$past(dst_sel_i)])
    else $error("overflow flag not set");

  sign_ext_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && !round_i && !pp.overflow)
      |=> acc[$past(dst_sel_i)][39:32] == {8{acc[$past(dst_sel_i)][31]}})
    else $error("result not sign extended");

  frac_shift_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && fractional_mode_bit_i && !saturate_on_multiply_bit_i && !round_i
      && !pp.overflow) |=> acc[$past(dst_sel_i)][0] == 1'b0)
    else $error("fractional shift missing");

  t3_copy_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && is_mem && t3_write_i) |=> third_temp_register == $past(data_operand_i))
    else $error("temp 3 copy missing");

  round_low_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && round_i && !pp.overflow) |=> acc[$past(dst_sel_i)][15:0] == 16'h0000)
    else $error("rounded result has low bits");

  sat32_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (write_en && pp.overflow && datapath_saturation_bit_i && !forty_bit_mode_bit_i)
      |=> (acc[$past(dst_sel_i)] == SAT_POS_32) || (acc[$past(dst_sel_i)] == SAT_NEG_32))
    else $error("32-bit saturation missing");

  illegal_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (is_mult && !opcode_ok) |=> illegal_o && !done_o)
    else $error("opcode mismatch not reported");
endmodule

// file: shared/fpmu_pkg.sv
// Package of constants and types for the fixed-point multiply unit
package fpmu_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ACC_W = 40;
  localparam int OPND_W = 17;
  localparam int PROD_W = 34;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_ACC = 4;
  localparam int ACC_IDX_W = 2;
  // Accumulator multiplier field, bits 32 down to 16
  localparam int ACC_MUL_HI = 32;
  localparam int ACC_MUL_LO = 16;
  // ****************************************
  // Opcode prefixes of the multiply forms
  // ****************************************
  localparam logic [6:0] OPC_IMM8_PFX = 7'h0F;   // 0001 111E, upper seven bits
  localparam logic [7:0] OPC_IMM16_PFX = 8'h79;  // 0111 1001
  localparam logic [7:0] OPC_COEF_PFX = 8'hD1;   // 1101 0001
  localparam logic [7:0] OPC_MEMACC_PFX = 8'hD3; // 1101 0011, ends 00SS
  // ****************************************
  // Rounding and saturation constants
  // ****************************************
  localparam logic [39:0] ROUND_ADD = 40'h0000008000;
  localparam logic [39:0] ROUND_LOW_MASK = 40'hFFFFFF0000;
  localparam logic [39:0] SAT_POS_32 = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_NEG_32 = 40'hFF80000000;
  localparam logic [39:0] SAT_POS_40 = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT_NEG_40 = 40'h8000000000;
  localparam logic [39:0] ACC_RESET = 40'h0000000000;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [33:0] SATURATE_ON_MULTIPLY_BIT_CORNER = 34'h080000000; // 0x8000 squared, shifted
  // ****************************************
  // Multiply forms
  // ****************************************
  typedef enum logic [2:0] {
    FPMU_OP_NONE,
    FPMU_OP_TEMP,      // accumulator high times temporary register
    FPMU_OP_IMM8,      // accumulator high times byte immediate
    FPMU_OP_IMM16,     // accumulator high times halfword immediate
    FPMU_OP_MEM_COEF,  // data memory times coefficient
    FPMU_OP_MEM_ACC,   // data memory times accumulator high
    FPMU_OP_MEM_IMM8   // data memory times byte immediate
  } fpmu_op_type;
endpackage

// file: shared/fpmu_post_if.sv
// Interface carrying a raw product and its post-processing controls
`timescale 1ns/1ps
interface fpmu_post_if;
  import fpmu_pkg::*;
  logic [PROD_W-1:0] raw_prod;
  logic fractional_mode_bit;
  logic forty_bit_mode_bit;
  logic rounding_mode_bit;
  logic datapath_saturation_bit;
  logic saturate_on_multiply_bit;
  logic round_req;
  logic ovf_enable;
  logic [ACC_W-1:0] result;
  logic overflow;
  modport core (output raw_prod, fractional_mode_bit, forty_bit_mode_bit, rounding_mode_bit,
    datapath_saturation_bit, saturate_on_multiply_bit, round_req, ovf_enable,
    input result, overflow);
  modport post (input raw_prod, fractional_mode_bit, forty_bit_mode_bit, rounding_mode_bit,
    datapath_saturation_bit, saturate_on_multiply_bit, round_req, ovf_enable,
    output result, overflow);
endinterface
